// *** wsr_pkg.sv ***
// Shared constants for the watchdog and stop-mode recovery block
package wsr_pkg;

  // Expanded register file location
  localparam logic [3:0] BANK_F = 4'hF;
  localparam logic [3:0] STOP_RCV_OFS = 4'hB;
  localparam logic [3:0] WD_MODE_OFS = 4'hF;

  // Reset values
  localparam logic [7:0] WD_MODE_RST = 8'h05;
  localparam logic [6:0] STOP_RCV_CTL_RST = 7'h00;

  // Watchdog mode field positions
  localparam int WD_SEL_LSB = 0;
  localparam int WD_HALT_BIT = 2;
  localparam int WD_STOP_BIT = 3;

  // Stop recovery field positions
  localparam int SR_DIV_LSB = 0;
  localparam int SR_SRC_LSB = 2;
  localparam int SR_DLY_BIT = 5;
  localparam int SR_POL_BIT = 6;
  localparam int SR_FLAG_BIT = 7;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WR_WINDOW_CYC = 60;
  localparam int RC_TICK_NS = 10000;
  localparam int RC_DIV_CYC = (RC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_T0_MS = 6;
  localparam int WD_T1_MS = 12;
  localparam int WD_T2_MS = 24;
  localparam int WD_T3_MS = 96;
  localparam int WD_T0_TICKS = WD_T0_MS * 1000000 / RC_TICK_NS;
  localparam int WD_T1_TICKS = WD_T1_MS * 1000000 / RC_TICK_NS;
  localparam int WD_T2_TICKS = WD_T2_MS * 1000000 / RC_TICK_NS;
  localparam int WD_T3_TICKS = WD_T3_MS * 1000000 / RC_TICK_NS;
  localparam int WD_TICK_W = 14;
  localparam int RC_DIV_W = 16;

  // Post-reset delay lengths
  localparam int RST_DLY_SHORT_CYC = 16;
  localparam int RST_DLY_LONG_CYC = 256;
  localparam int RST_DLY_W = 9;

  // Write window counter width
  localparam int WIN_W = 7;

endpackage : wsr_pkg

// *** wsr_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module wsr_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] stab_d;

  // First stage feeds only the second stage
  always_comb begin
    meta_d = async_i;
    stab_d = meta_q;
  end

  // Pins idle high so wake sources do not fire out of reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      stab_q <= '1;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign sync_o = stab_q;

endmodule : wsr_sync

`default_nettype wire

// *** wsr_wd_counter.sv ***
// Watchdog counter driven by a free-running oscillator tick
`timescale 1ns/1ps
`default_nettype none

module wsr_wd_counter #(
  parameter int RC_DIV = wsr_pkg::RC_DIV_CYC,
  parameter int T0_TICKS = wsr_pkg::WD_T0_TICKS,
  parameter int T1_TICKS = wsr_pkg::WD_T1_TICKS,
  parameter int T2_TICKS = wsr_pkg::WD_T2_TICKS,
  parameter int T3_TICKS = wsr_pkg::WD_T3_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [1:0] sel_i,
  output logic timeout_o
);

  logic [wsr_pkg::RC_DIV_W-1:0] div_q;
  logic [wsr_pkg::RC_DIV_W-1:0] div_d;
  logic tick;
  logic [wsr_pkg::WD_TICK_W-1:0] cnt_q;
  logic [wsr_pkg::WD_TICK_W-1:0] cnt_d;
  logic [wsr_pkg::WD_TICK_W-1:0] limit;
  logic to_q;
  logic to_d;

  // Oscillator stand-in: it never stops, so halt and stop do not freeze it
  always_comb begin
    tick = (div_q == wsr_pkg::RC_DIV_W'(RC_DIV - 1));
    div_d = tick ? '0 : div_q + 1'b1;
  end

  always_comb begin
    unique case (sel_i)
      2'h0: limit = wsr_pkg::WD_TICK_W'(T0_TICKS);
      2'h1: limit = wsr_pkg::WD_TICK_W'(T1_TICKS);
      2'h2: limit = wsr_pkg::WD_TICK_W'(T2_TICKS);
      2'h3: limit = wsr_pkg::WD_TICK_W'(T3_TICKS);
    endcase
  end

  always_comb begin
    cnt_d = cnt_q;
    to_d = 1'b0;
    if (restart_i) begin
      cnt_d = '0;
    end else if (tick && run_i) begin
      if (cnt_q + 1'b1 >= limit) begin
        cnt_d = '0;
        to_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
      cnt_q <= '0;
      to_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      to_q <= to_d;
    end
  end

  assign timeout_o = to_q;

endmodule : wsr_wd_counter

`default_nettype wire

// *** wsr_top.sv ***
// Watchdog mode control and stop-mode recovery control for bank F
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Watchdog counts from its own free oscillator
// - Mode bit 2 keeps watchdog running in halt
// - Mode bit 3 keeps watchdog running in stop
// - Mode bits 1-0 pick 6/12/24/96 ms
// - Timeout in halt or stop restores defaults
// - Mode writes only in 60 cycles after start
// - Recovery flag bit 7, cleared only by power-on
// - Other recovery bits are write-only
// - Bit 6 picks wake level low or high
// - Bit 5 picks post-recovery reset delay
// - Bits 4-2 pick the wake source
// - Bits 1-0 set system clock divider
// - Low on wake pin wakes from stop
// - Recovery resets differ from standard reset
// - Registers at bank F offsets 0Bh, 0Fh
module wsr_top #(
  parameter int RC_DIV = wsr_pkg::RC_DIV_CYC,
  parameter int T0_TICKS = wsr_pkg::WD_T0_TICKS,
  parameter int T1_TICKS = wsr_pkg::WD_T1_TICKS,
  parameter int T2_TICKS = wsr_pkg::WD_T2_TICKS,
  parameter int T3_TICKS = wsr_pkg::WD_T3_TICKS,
  parameter int DLY_SHORT = wsr_pkg::RST_DLY_SHORT_CYC,
  parameter int DLY_LONG = wsr_pkg::RST_DLY_LONG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] bank_i,
  input wire logic [3:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic first_instr_i,
  input wire logic wd_refresh_i,
  input wire logic halt_mode_i,
  input wire logic stop_mode_i,
  input wire logic wake_pin_port2_bit7_i,
  input wire logic [6:0] wake_src_i,
  output logic sys_reset_o,
  output logic special_reset_o,
  output logic wd_reset_o,
  output logic recovery_o,
  output logic [1:0] clk_div_sel_o,
  output logic wr_window_o
);

  typedef enum logic [1:0] {
    WSR_WIN_WAIT,
    WSR_WIN_OPEN,
    WSR_WIN_SHUT
  } wsr_win_t;

  // Register selects
  logic sel_stop_rcv;
  logic sel_wd_mode;

  // Watchdog mode register
  logic [7:0] wd_mode_q;
  logic [7:0] wd_mode_d;

  // Stop recovery register: flag plus write-only controls
  logic rcv_flag_q;
  logic rcv_flag_d;
  logic [6:0] rcv_ctl_q;
  logic [6:0] rcv_ctl_d;

  // Write window
  wsr_win_t win_q;
  wsr_win_t win_d;
  logic [wsr_pkg::WIN_W-1:0] win_cnt_q;
  logic [wsr_pkg::WIN_W-1:0] win_cnt_d;

  // Registered copy of the open state, so the port leaves a flip-flop
  logic win_open_q;
  logic win_open_d;

  // Internal reset sequencing
  logic rst_act_q;
  logic rst_act_d;
  logic rst_spec_q;
  logic rst_spec_d;
  logic [wsr_pkg::RST_DLY_W-1:0] dly_q;
  logic [wsr_pkg::RST_DLY_W-1:0] dly_d;

  // Outputs
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic wd_rst_q;
  logic wd_rst_d;
  logic rcv_q;
  logic rcv_d;
  logic [1:0] div_q;
  logic [1:0] div_d;

  // Watchdog and wake sources
  logic wd_run;
  logic wd_timeout;
  logic [7:0] wake_sync;
  logic wake_level;
  logic wake_hit;
  logic [2:0] src_sel;

  assign sel_stop_rcv = (bank_i == wsr_pkg::BANK_F) && (addr_i == wsr_pkg::STOP_RCV_OFS);
  assign sel_wd_mode = (bank_i == wsr_pkg::BANK_F) && (addr_i == wsr_pkg::WD_MODE_OFS);

  // Pin levels come from outside the clock domain
  // Levels are sampled, so a wake pulse under one cycle may be missed
  wsr_sync #(
    .WIDTH(8)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({wake_src_i, wake_pin_port2_bit7_i}),
    .sync_o(wake_sync)
  );

  // Counter is cleared and held at zero while a reset sequence runs
  // Stop is checked first: a halted core that enters stop follows bit 3
  always_comb begin
    if (stop_mode_i) begin
      wd_run = wd_mode_q[wsr_pkg::WD_STOP_BIT];
    end else if (halt_mode_i) begin
      wd_run = wd_mode_q[wsr_pkg::WD_HALT_BIT];
    end else begin
      wd_run = 1'b1;
    end
    wd_run = wd_run && !rst_act_q;
  end

  wsr_wd_counter #(
    .RC_DIV(RC_DIV),
    .T0_TICKS(T0_TICKS),
    .T1_TICKS(T1_TICKS),
    .T2_TICKS(T2_TICKS),
    .T3_TICKS(T3_TICKS)
  ) u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(wd_run),
    .restart_i(wd_refresh_i || rst_act_q),
    .sel_i(wd_mode_q[wsr_pkg::WD_SEL_LSB +: 2]),
    .timeout_o(wd_timeout)
  );

  // Source 0 is the wake pin; the others map to the extra inputs
  always_comb begin
    src_sel = rcv_ctl_q[wsr_pkg::SR_SRC_LSB +: 3];
    wake_level = wake_sync[src_sel];
    // Default polarity 0 gives the simple low-level pin wake
    wake_hit = stop_mode_i && !rst_act_q
      && (wake_level == rcv_ctl_q[wsr_pkg::SR_POL_BIT]);
  end

  // Write window opens at the first instruction after any reset
  always_comb begin
    win_d = win_q;
    win_cnt_d = win_cnt_q;
    if (rst_act_q) begin
      win_d = WSR_WIN_WAIT;
      win_cnt_d = '0;
    end else begin
      unique case (win_q)
        WSR_WIN_WAIT: begin
          if (first_instr_i) begin
            win_d = WSR_WIN_OPEN;
            win_cnt_d = wsr_pkg::WIN_W'(wsr_pkg::WR_WINDOW_CYC - 1);
          end
        end
        WSR_WIN_OPEN: begin
          if (win_cnt_q == '0) begin
            win_d = WSR_WIN_SHUT;
          end else begin
            win_cnt_d = win_cnt_q - 1'b1;
          end
        end
        WSR_WIN_SHUT: begin
          win_d = WSR_WIN_SHUT;
        end
      endcase
    end
    win_open_d = (win_d == WSR_WIN_OPEN);
  end

  // Register writes
  always_comb begin
    wd_mode_d = wd_mode_q;
    rcv_ctl_d = rcv_ctl_q;
    if (rst_act_q) begin
      wd_mode_d = wsr_pkg::WD_MODE_RST;
      // A standard internal reset clears controls; recovery keeps them
      if (!rst_spec_q) begin
        rcv_ctl_d = wsr_pkg::STOP_RCV_CTL_RST;
      end
    end else if (wr_i) begin
      if (sel_wd_mode && (win_q == WSR_WIN_OPEN)) begin
        // Upper bits are stored as written; software keeps them zero
        wd_mode_d = wdata_i;
      end
      if (sel_stop_rcv) begin
        rcv_ctl_d = wdata_i[6:0];
      end
    end
  end

  // Flag is set by hardware and only a power-on reset clears it
  // No software clear exists, so a set can never race a clear
  always_comb begin
    rcv_flag_d = rcv_flag_q;
    if (wake_hit || (wd_timeout && stop_mode_i)) begin
      rcv_flag_d = 1'b1;
    end
  end

  // Internal reset sequence with selectable length
  always_comb begin
    rst_act_d = rst_act_q;
    rst_spec_d = rst_spec_q;
    dly_d = dly_q;
    wd_rst_d = 1'b0;
    rcv_d = 1'b0;
    if (!rst_act_q && (wake_hit || wd_timeout)) begin
      rst_act_d = 1'b1;
      // Special kind only for stop recovery or a timeout during stop
      rst_spec_d = wake_hit || stop_mode_i;
      wd_rst_d = wd_timeout;
      rcv_d = wake_hit;
      // Length is fixed at the trigger; writes during the reset are refused
      if (rcv_ctl_q[wsr_pkg::SR_DLY_BIT]) begin
        dly_d = wsr_pkg::RST_DLY_W'(DLY_LONG - 1);
      end else begin
        dly_d = wsr_pkg::RST_DLY_W'(DLY_SHORT - 1);
      end
    end else if (rst_act_q) begin
      if (dly_q == '0) begin
        rst_act_d = 1'b0;
        rst_spec_d = 1'b0;
      end else begin
        dly_d = dly_q - 1'b1;
      end
    end
  end

  // Read path: mode register is write-only and reads as zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_i) begin
      if (sel_stop_rcv) begin
        rdata_d = {rcv_flag_q, 7'h00};
      end else begin
        rdata_d = 8'h00;
      end
    end
    // Divider copy is registered, so it follows a write one cycle late
    div_d = rcv_ctl_q[wsr_pkg::SR_DIV_LSB +: 2];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_mode_q <= wsr_pkg::WD_MODE_RST;
      rcv_flag_q <= 1'b0;
      rcv_ctl_q <= wsr_pkg::STOP_RCV_CTL_RST;
      win_q <= WSR_WIN_WAIT;
      win_cnt_q <= '0;
      win_open_q <= 1'b0;
      rst_act_q <= 1'b0;
      rst_spec_q <= 1'b0;
      dly_q <= '0;
      rdata_q <= 8'h00;
      wd_rst_q <= 1'b0;
      rcv_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      wd_mode_q <= wd_mode_d;
      rcv_flag_q <= rcv_flag_d;
      rcv_ctl_q <= rcv_ctl_d;
      win_q <= win_d;
      win_cnt_q <= win_cnt_d;
      win_open_q <= win_open_d;
      rst_act_q <= rst_act_d;
      rst_spec_q <= rst_spec_d;
      dly_q <= dly_d;
      rdata_q <= rdata_d;
      wd_rst_q <= wd_rst_d;
      rcv_q <= rcv_d;
      div_q <= div_d;
    end
  end

  assign rdata_o = rdata_q;
  assign sys_reset_o = rst_act_q;
  assign special_reset_o = rst_spec_q;
  assign wd_reset_o = wd_rst_q;
  assign recovery_o = rcv_q;
  assign clk_div_sel_o = div_q;
  assign wr_window_o = win_open_q;

endmodule : wsr_top

`default_nettype wire

// *** wsr_checker.sv ***
// Port assertions for the watchdog and stop recovery block
`timescale 1ns/1ps
`default_nettype none
module wsr_checker #(
  parameter int DLY_SHORT = 16,
  parameter int DLY_LONG = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] bank_i,
  input wire logic [3:0] addr_i,
  input wire logic rd_i,
  input wire logic first_instr_i,
  input wire logic stop_mode_i,
  input wire logic [7:0] rdata_o,
  input wire logic sys_reset_o,
  input wire logic special_reset_o,
  input wire logic wd_reset_o,
  input wire logic recovery_o,
  input wire logic wr_window_o
);
  int win_q, win_d, len_q, len_d;
  // Run lengths so far, since repetition counts of 60 or 256 would not unroll cheaply
  always_comb begin
    win_d = wr_window_o ? win_q + 1 : 0;
    len_d = sys_reset_o ? len_q + 1 : 0;
  end
  always_ff @(posedge clk_i) begin
    win_q <= rst_i ? 0 : win_d;
    len_q <= rst_i ? 0 : len_d;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  rst_out_a: assert property (disable iff (1'b0) rst_i |=> !sys_reset_o
    && !wr_window_o && !wd_reset_o && !recovery_o && rdata_o == 8'h00)
    else $error("outputs not cleared");
  win_len_a: assert property (wr_window_o |-> win_q < 60)
    else $error("window too long");
  win_full_a: assert property ($fell(wr_window_o) && !sys_reset_o |-> win_q == 60)
    else $error("window too short");
  win_open_a: assert property ($rose(wr_window_o) |-> $past(first_instr_i))
    else $error("window opened without start");
  wd_start_a: assert property (wd_reset_o |-> $rose(sys_reset_o))
    else $error("timeout without reset");
  wd_pulse_a: assert property (wd_reset_o |=> !wd_reset_o)
    else $error("timeout pulse too long");
  rcv_start_a: assert property (recovery_o |-> $rose(sys_reset_o)
    && special_reset_o && $past(stop_mode_i)) else $error("bad recovery start");
  rcv_pulse_a: assert property (recovery_o |=> !recovery_o)
    else $error("recovery pulse too long");
  rst_len_a: assert property ($fell(sys_reset_o) |-> len_q == DLY_SHORT
    || len_q == DLY_LONG) else $error("reset length wrong");
  spec_in_a: assert property (special_reset_o |-> sys_reset_o)
    else $error("special reset outside reset");
  rd_low_a: assert property (rd_i |=> rdata_o[6:0] == 7'h00)
    else $error("write-only bits read back");
  rd_map_a: assert property (rd_i && !(bank_i == 4'hF && addr_i == 4'hB) |=>
    rdata_o == 8'h00) else $error("unexpected read data");
  cover property ($rose(wr_window_o));
  cover property (wd_reset_o && special_reset_o);
  cover property (recovery_o);
  cover property ($fell(sys_reset_o) && len_q == DLY_LONG);
endmodule : wsr_checker
bind wsr_top wsr_checker #(.DLY_SHORT(DLY_SHORT), .DLY_LONG(DLY_LONG)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .bank_i(bank_i), .addr_i(addr_i), .rd_i(rd_i),
  .first_instr_i(first_instr_i), .stop_mode_i(stop_mode_i), .rdata_o(rdata_o),
  .sys_reset_o(sys_reset_o), .special_reset_o(special_reset_o), .wd_reset_o(wd_reset_o),
  .recovery_o(recovery_o), .wr_window_o(wr_window_o));
`default_nettype wire

// *** wsr_top_tb.sv ***
// Self-checking bench for the watchdog and stop recovery block
`timescale 1ns/1ps
`default_nettype none
module wsr_top_tb;
  localparam int RCD = 2;
  localparam int TK [4] = '{4, 8, 16, 32};
  localparam int DS = 4;
  localparam int DL = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] bank_i = 4'h0;
  logic [3:0] addr_i = 4'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic first_instr_i = 1'b0;
  logic wd_refresh_i = 1'b0;
  logic halt_mode_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic wake_pin_port2_bit7_i = 1'b1;
  logic [6:0] wake_src_i = 7'h7F;
  logic [7:0] rdata_o, v, ln;
  logic sys_reset_o, special_reset_o, wd_reset_o, recovery_o, wr_window_o;
  logic [1:0] clk_div_sel_o;
  logic refresh_en = 1'b1;
  int bad_count = 0;
  int comparisons = 0;
  int n, seed;
  wsr_top #(.RC_DIV(RCD), .T0_TICKS(TK[0]), .T1_TICKS(TK[1]), .T2_TICKS(TK[2]),
    .T3_TICKS(TK[3]), .DLY_SHORT(DS), .DLY_LONG(DL)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .bank_i(bank_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .first_instr_i(first_instr_i), .wd_refresh_i(wd_refresh_i),
    .halt_mode_i(halt_mode_i), .stop_mode_i(stop_mode_i),
    .wake_pin_port2_bit7_i(wake_pin_port2_bit7_i), .wake_src_i(wake_src_i),
    .sys_reset_o(sys_reset_o), .special_reset_o(special_reset_o), .wd_reset_o(wd_reset_o),
    .recovery_o(recovery_o), .clk_div_sel_o(clk_div_sel_o), .wr_window_o(wr_window_o));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) wd_refresh_i <= refresh_en;
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bank_i <= 4'hF;
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] b, input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    bank_i <= b;
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  // Event 0 timeout pulse, 1 recovery pulse, 2 end of internal reset
  task automatic wait_for(input int w, input int lim, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      #1 k++;
      if (k > lim) begin
        bad_count++;
        $display("[FAIL] wait %0d expected event seen none", w);
        report_and_stop();
      end
    end while (!(w == 0 ? wd_reset_o === 1'b1 : w == 1 ? recovery_o === 1'b1 :
      sys_reset_o === 1'b0));
  endtask : wait_for
  task automatic quiet(input int k);
    int c;
    c = 0;
    repeat (k) begin
      @(posedge clk_i);
      #1 c += int'(wd_reset_o === 1'b1 || recovery_o === 1'b1);
    end
    chk_rng("quiet events", 0, 0, c);
  endtask : quiet
  task automatic open_win();
    @(posedge clk_i);
    first_instr_i <= 1'b1;
    @(posedge clk_i);
    first_instr_i <= 1'b0;
  endtask : open_win
  // Tick phase is free running, so the expiry is only known to within one divider period
  task automatic expect_to(input int s, input logic sp);
    @(posedge clk_i);
    refresh_en <= 1'b0;
    wait_for(0, 3 * TK[s] * RCD + 20, n);
    chk_rng("timeout", TK[s] * RCD - 1, TK[s] * RCD + RCD + 2, n);
    chk8("special", {7'h00, sp}, {7'h00, special_reset_o});
    refresh_en <= 1'b1;
    stop_mode_i <= 1'b0;
    halt_mode_i <= 1'b0;
    wait_for(2, 300, n);
    $display("test timeout sel %0d done", s);
  endtask : expect_to
  initial begin
    seed = $urandom(27154);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'hF, 4'hB, v);
    chk8("recovery read", 8'h00, v);
    rd(4'hF, 4'hF, v);
    chk8("mode read", 8'h00, v);
    rd(4'h3, 4'hB, v);
    chk8("unmapped read", 8'h00, v);
    $display("test register reads done");
    open_win();
    n = 0;
    repeat (80) begin
      #1 n += int'(wr_window_o === 1'b1);
      @(posedge clk_i);
    end
    chk_rng("window length", 60, 60, n);
    wr(4'hF, 8'h00);
    expect_to(1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      open_win();
      v = 8'($urandom);
      wr(4'hF, {4'h0, v[3:2], 2'(s)});
      expect_to(s, 1'b0);
    end
    open_win();
    wr(4'hF, 8'h00);
    halt_mode_i <= 1'b1;
    refresh_en <= 1'b0;
    quiet(4 * TK[0] * RCD);
    halt_mode_i <= 1'b0;
    refresh_en <= 1'b1;
    expect_to(0, 1'b0);
    halt_mode_i <= 1'b1;
    expect_to(1, 1'b0);
    $display("test halt done");
    stop_mode_i <= 1'b1;
    refresh_en <= 1'b0;
    quiet(4 * TK[1] * RCD);
    stop_mode_i <= 1'b0;
    refresh_en <= 1'b1;
    open_win();
    wr(4'hF, 8'h08);
    stop_mode_i <= 1'b1;
    expect_to(0, 1'b1);
    $display("test stop done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[4:2] = 3'(i);
      if (i == 0) v[6] = 1'b0;
      wr(4'hB, v);
      ln = {8{~v[6]}};
      ln[(i + 1) % 8] = v[6];
      {wake_src_i, wake_pin_port2_bit7_i} <= ln;
      repeat (3) @(posedge clk_i);
      stop_mode_i <= 1'b1;
      quiet(10);
      ln[i] = v[6];
      {wake_src_i, wake_pin_port2_bit7_i} <= ln;
      wait_for(1, 10, n);
      chk_rng("wake latency", 2, 4, n);
      stop_mode_i <= 1'b0;
      wait_for(2, 300, n);
      chk_rng("reset length", v[5] ? DL : DS, v[5] ? DL : DS, n);
      chk8("divider", {6'h00, v[1:0]}, {6'h00, clk_div_sel_o});
      rd(4'hF, 4'hB, v);
      chk8("flag read", 8'h80, v);
      $display("test recovery source %0d done", i);
    end
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'hF, 4'hB, v);
    chk8("flag after power-on", 8'h00, v);
    $display("test power-on clear done");
    report_and_stop();
  end
endmodule : wsr_top_tb
`default_nettype wire
